// >>> src/quad_div_pkg.sv
// Constants shared by the quadrature divider and error monitor
package quad_div_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ          = 20_000_000;
  localparam int LATENCY_NS      = 3000;       // Typical pass-through delay
  localparam int LATENCY_CYC     = (LATENCY_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int WARMUP_CYCLES   = 20;         // Full input sine periods
  localparam int WARMUP_STEPS    = WARMUP_CYCLES * 4;
  localparam int CFG_WAIT        = 3;          // Cycles before strap capture

  // ------------------------------------------------------------------
  // Setting widths and reset values
  // ------------------------------------------------------------------
  localparam int PHASE_CODE_W    = 8;
  localparam int REF_CODE_W      = 4;
  localparam int CFG_W           = PHASE_CODE_W + REF_CODE_W + 1;
  localparam logic [PHASE_CODE_W-1:0] PHASE_CODE_RST = 8'h00;
  localparam logic [REF_CODE_W-1:0]   REF_CODE_RST   = 4'h0;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam int ADDR_W          = 8;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00; // Sticky events, W1C
  localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h04; // Interrupt mask
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h08; // Settings in force, RO
  localparam logic [ADDR_W-1:0] OFS_STATE  = 8'h0C; // Live state, RO
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h10; // Write 1 to release

  // Event bit positions (status and mask share the layout)
  localparam int EV_WIRE         = 0;
  localparam int EV_AMP          = 1;
  localparam int EV_SPEED        = 2;
  localparam int EV_ERROR        = 3;
  localparam int EV_SETTLED      = 4;
  localparam int EV_W            = 5;
  localparam logic [EV_W-1:0] EV_RST = 5'h00;

  // Control register bit
  localparam int CTRL_RELEASE    = 0;

  // Startup sequencer, one-hot
  typedef enum logic [2:0] {
    ST_CFG  = 3'b001,
    ST_WARM = 3'b010,
    ST_RUN  = 3'b100
  } start_state_t;

endpackage

// >>> src/step_divider.sv
// Up/down step divider: one output step per (code + 1) input steps
module step_divider
  import quad_div_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Ratio code and input steps
  input  wire logic [W-1:0] i_code,
  input  wire logic         i_up,
  input  wire logic         i_dn,
  // Divided steps
  output logic              o_up,
  output logic              o_dn
);

  logic [W-1:0] cnt;

  // Wrap points: counting both ways around one modulus keeps direction
  wire up_wrap = i_up && (cnt == i_code);
  wire dn_wrap = i_dn && (cnt == '0);

  // Counter and pulses; a reversal unwinds the count, so no false steps
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt  <= '0;
      o_up <= 1'b0;
      o_dn <= 1'b0;
    end else begin
      o_up <= up_wrap;
      o_dn <= dn_wrap;
      if (up_wrap) begin
        cnt <= '0;
      end else if (i_up) begin
        cnt <= cnt + W'(1);
      end else if (dn_wrap) begin
        cnt <= i_code;
      end else if (i_dn) begin
        cnt <= cnt - W'(1);
      end
    end
  end

endmodule

// >>> src/quadrature_divider_error_monitor.sv
// Quadrature output divider with sine/cosine error monitor
//
// Functional notes
// - Two-phase output frequency is divided by an integer 1 to 256.
// - Eight-bit phase code N gives ratio 1:(N+1); all ones gives 1:256.
// - Reference output has own divider, four-bit code N gives 1:(N+1).
// - Wire break on any of the four sine/cosine lines flags an error.
// - Too low amplitude on any sine/cosine line flags an error.
// - Reference input pair is not monitored; its faults raise nothing.
// - Input frequency above supported maximum flags an error.
// - A setting selects latched-until-acknowledged or self-clearing errors.
// - Mode setting on: error never latched; off: held until cleared.
// - Error drives error output high and lights the indicator together.
// - Latched error cleared by release input or front pushbutton.
// - Acknowledge cannot clear while over-speed persists; it re-asserts.
// - Switch settings are sampled once at power-up only.
// - Undivided latency is about 3 us and constant over frequency.
// - With division active latency grows with the division applied.
// - Full accuracy after about 20 input sine cycles from start-up.
//
// Implementation choices: the address-and-strobe port and the register addresses.
module quadrature_divider_error_monitor
  import quad_div_pkg::*;
#(
  parameter int LAT = LATENCY_CYC
) (
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  // Interpolated quadrature from the core (same clock)
  input  wire logic                    i_quad_a,
  input  wire logic                    i_quad_b,
  input  wire logic                    i_ref_mark,
  input  wire logic                    i_core_overspeed,
  // Analogue front-end fault pins: sin+, sin-, cos+, cos-
  input  wire logic [3:0]              i_wire_break,
  input  wire logic [3:0]              i_low_amplitude,
  // Acknowledge pins
  input  wire logic                    i_error_release,
  input  wire logic                    i_front_button,
  // Configuration switch pins
  input  wire logic [PHASE_CODE_W-1:0] i_phase_div_code,
  input  wire logic [REF_CODE_W-1:0]   i_ref_div_code,
  input  wire logic                    i_fault_mode_select,
  // Register port
  input  wire logic [ADDR_W-1:0]       i_addr,
  input  wire logic [31:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [31:0]             o_rdata,
  // Divided quadrature outputs
  output logic                         o_quad_a,
  output logic                         o_quad_b,
  output logic                         o_ref_mark,
  // Error signalling
  output logic                         o_error,
  output logic                         o_error_led,
  output logic                         o_irq
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Straps share the chain, so every pin sees the same two-cycle delay
  localparam int SYNC_W = 8 + 2 + CFG_W;
  logic [SYNC_W-1:0] sync_1;
  logic [SYNC_W-1:0] sync_2;
  wire  [SYNC_W-1:0] pins_in = {i_wire_break, i_low_amplitude,
                                i_error_release, i_front_button,
                                i_fault_mode_select, i_ref_div_code,
                                i_phase_div_code};

  // Only the second stage is read; the first may be metastable
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync_1 <= '0;
      sync_2 <= '0;
    end else begin
      sync_1 <= pins_in;
      sync_2 <= sync_1;
    end
  end

  wire [3:0]             wire_s   = sync_2[SYNC_W-1 -: 4];
  wire [3:0]             amp_s    = sync_2[SYNC_W-5 -: 4];
  wire                   rel_s    = sync_2[CFG_W+1];
  wire                   btn_s    = sync_2[CFG_W];
  wire [CFG_W-1:0]       cfg_s    = sync_2[CFG_W-1:0];

  // ----------------------------------------------------------------
  // Start-up: strap capture and warm-up
  // ----------------------------------------------------------------
  // The straps come through the synchroniser, so capture waits a few
  // cycles for it to fill. Warm-up only counts steps; outputs run
  // ungated so a drive sees motion at once, at reduced accuracy.
  start_state_t               state;
  start_state_t               next_state;
  logic [1:0]                 cfg_cnt;
  logic [7:0]                 warm_cnt;
  logic [PHASE_CODE_W-1:0]    phase_code;
  logic [REF_CODE_W-1:0]      ref_code;
  logic                       fault_mode;

  wire cfg_ready  = (cfg_cnt == 2'(CFG_WAIT));
  wire warm_done  = (warm_cnt == 8'(WARMUP_STEPS));

  // Next startup state
  always_comb begin
    next_state = state;
    case (state)
      ST_CFG:  if (cfg_ready) next_state = ST_WARM;
      ST_WARM: if (warm_done) next_state = ST_RUN;
      ST_RUN:  next_state = ST_RUN;
      default: next_state = ST_CFG;
    endcase
  end

  // Straps are taken once after reset; later switch moves are ignored
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state      <= ST_CFG;
      cfg_cnt    <= 2'h0;
      phase_code <= PHASE_CODE_RST;
      ref_code   <= REF_CODE_RST;
      fault_mode <= 1'b0;
    end else begin
      state <= next_state;
      if (state == ST_CFG && !cfg_ready) begin
        cfg_cnt <= cfg_cnt + 2'h1;
      end
      if (state == ST_CFG && cfg_ready) begin
        phase_code <= cfg_s[PHASE_CODE_W-1:0];
        ref_code   <= cfg_s[PHASE_CODE_W +: REF_CODE_W];
        fault_mode <= cfg_s[CFG_W-1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Quadrature decode of the interpolated phases
  // ----------------------------------------------------------------
  // Position index turns the Gray phases into a binary count modulo four
  logic [1:0] pos_prev;
  logic       ref_prev;
  wire  [1:0] pos_now  = {i_quad_a, i_quad_a ^ i_quad_b};
  wire  [1:0] pos_diff = pos_now - pos_prev;
  wire        step_up  = (pos_diff == 2'h1);
  wire        step_dn  = (pos_diff == 2'h3);
  // Two phases moving at once means edges came faster than sampled
  wire        step_jump = (pos_diff == 2'h2);
  wire        ref_rise  = i_ref_mark && !ref_prev;

  // Previous samples follow the inputs in reset as well, so a core that
  // rests off phase zero or on a mark gives no false step when it ends
  always_ff @(posedge i_clk) begin
    pos_prev <= pos_now;
    ref_prev <= i_ref_mark;
    if (i_rst) begin
      warm_cnt <= 8'h00;
    end else begin
      if (state == ST_WARM && (step_up || step_dn) && !warm_done) begin
        warm_cnt <= warm_cnt + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Dividers
  // ----------------------------------------------------------------
  // Both dividers are the same up/down counter. The reference one is
  // fed rises only, so its down port is tied off; a mark has no sense
  // of direction to keep.
  logic div_up;
  logic div_dn;
  logic ref_step;

  // Phase divider, ratio 1:(code+1); up and down share one count
  step_divider #(.W(PHASE_CODE_W)) u_phase_div (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_code (phase_code),
    .i_up   (step_up),
    .i_dn   (step_dn),
    .o_up   (div_up),
    .o_dn   (div_dn)
  );

  // Reference divider passes every (code+1)-th mark
  step_divider #(.W(REF_CODE_W)) u_ref_div (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_code (ref_code),
    .i_up   (ref_rise),
    .i_dn   (1'b0),
    .o_up   (ref_step),
    .o_dn   ()
  );

  // Divided position; a pass-through mark stays high while input does
  logic [1:0] out_pos;
  logic       ref_open;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      out_pos  <= 2'h0;
      ref_open <= 1'b0;
    end else begin
      if (div_up) begin
        out_pos <= out_pos + 2'h1;
      end else if (div_dn) begin
        out_pos <= out_pos - 2'h1;
      end
      if (ref_step) begin
        ref_open <= 1'b1;
      end else if (!ref_prev) begin
        ref_open <= 1'b0;
      end
    end
  end

  wire out_a = out_pos[1];
  wire out_b = out_pos[1] ^ out_pos[0];
  wire out_z = ref_open && ref_prev;

  // ----------------------------------------------------------------
  // Fixed latency line
  // ----------------------------------------------------------------
  // A fixed delay keeps phase lag linear in frequency; dividing adds
  // the wait for the extra input edges on top of it
  // Cost: three shift registers of LAT flops each; LAT must be 2 or more
  logic [LAT-1:0] dly_a;
  logic [LAT-1:0] dly_b;
  logic [LAT-1:0] dly_z;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dly_a    <= '0;
      dly_b    <= '0;
      dly_z    <= '0;
      o_quad_a <= 1'b0;
      o_quad_b <= 1'b0;
      o_ref_mark <= 1'b0;
    end else begin
      dly_a      <= {dly_a[LAT-2:0], out_a};
      dly_b      <= {dly_b[LAT-2:0], out_b};
      dly_z      <= {dly_z[LAT-2:0], out_z};
      o_quad_a   <= dly_a[LAT-1];
      o_quad_b   <= dly_b[LAT-1];
      o_ref_mark <= dly_z[LAT-1];
    end
  end

  // ----------------------------------------------------------------
  // Error monitor
  // ----------------------------------------------------------------
  // Pin causes arrive two cycles late through the synchroniser while
  // the over-speed flag is same-clock; the skew is far below any
  // acknowledge a user could give, so it is not equalised.
  // Reference lines have no fault inputs at all, so they never trip
  wire wire_err   = |wire_s;
  wire amp_err    = |amp_s;
  wire speed_err  = i_core_overspeed || step_jump;
  wire cause      = wire_err || amp_err || speed_err;
  logic sw_release;
  wire release_req = rel_s || btn_s || sw_release;

  // Cause sets last, so it beats an acknowledge in the same cycle
  logic err;
  wire  next_err = fault_mode ? cause
                 : (cause || (err && !release_req));

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      err         <= 1'b0;
      o_error     <= 1'b0;
      o_error_led <= 1'b0;
    end else begin
      err         <= next_err;
      o_error     <= next_err;
      o_error_led <= next_err;
    end
  end

  // ----------------------------------------------------------------
  // Register port and interrupt
  // ----------------------------------------------------------------
  // Map: STATUS sticky events cleared by writing ones, MASK of the same
  // layout, CONFIG the settings captured after reset, STATE the live
  // causes and run flag, CTRL bit 0 a one-shot software release.
  // Event bits: wire break, low amplitude, over-speed, error rising and
  // warm-up done. A cause still present re-sets its bit in the cycle of
  // the clear, so software cannot lose an event by clearing too early.
  // Unmapped reads return zero and unmapped writes are dropped, which
  // keeps the map free to grow without breaking old drivers.
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] mask;
  logic            settled_q;

  wire wr_status = i_wr && (i_addr == OFS_STATUS);
  wire wr_mask   = i_wr && (i_addr == OFS_MASK);
  wire wr_ctrl   = i_wr && (i_addr == OFS_CTRL);

  wire [EV_W-1:0] ev_set;
  assign ev_set[EV_WIRE]    = wire_err;
  assign ev_set[EV_AMP]     = amp_err;
  assign ev_set[EV_SPEED]   = speed_err;
  assign ev_set[EV_ERROR]   = next_err && !err;
  assign ev_set[EV_SETTLED] = (state == ST_RUN) && !settled_q;

  wire [EV_W-1:0] ev_clr  = wr_status ? i_wdata[EV_W-1:0] : '0;
  wire [EV_W-1:0] next_status = (status & ~ev_clr) | ev_set;

  wire [31:0] cfg_word   = {19'h0, fault_mode, ref_code, phase_code};
  wire [31:0] state_word = {27'h0, state == ST_RUN, err,
                            speed_err, amp_err, wire_err};
  wire [31:0] rd_mux =
      (i_addr == OFS_STATUS) ? {27'h0, status} :
      (i_addr == OFS_MASK)   ? {27'h0, mask}   :
      (i_addr == OFS_CONFIG) ? cfg_word        :
      (i_addr == OFS_STATE)  ? state_word      : 32'h0000_0000;

  // Status, mask, release pulse, read data and interrupt
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      status     <= EV_RST;
      mask       <= EV_RST;
      settled_q  <= 1'b0;
      sw_release <= 1'b0;
      o_rdata    <= 32'h0000_0000;
      o_irq      <= 1'b0;
    end else begin
      status     <= next_status;
      settled_q  <= (state == ST_RUN);
      sw_release <= wr_ctrl && i_wdata[CTRL_RELEASE];
      if (wr_mask) begin
        mask <= i_wdata[EV_W-1:0];
      end
      o_rdata    <= i_rd ? rd_mux : 32'h0000_0000;
      o_irq      <= |(next_status & mask);
    end
  end

endmodule

// >>> dv/quad_div_properties.sv
// Port checks for the quadrature divider and error monitor
module quad_div_checker
  import quad_div_pkg::*;
#(
  parameter int LAT = LATENCY_CYC
) (
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_rst,
  // Inputs watched
  input wire logic       i_quad_a,
  input wire logic       i_quad_b,
  input wire logic       i_core_overspeed,
  input wire logic [3:0] i_wire_break,
  input wire logic [3:0] i_low_amplitude,
  // Outputs watched
  input wire logic       o_quad_a,
  input wire logic       o_quad_b,
  input wire logic       o_error,
  input wire logic       o_error_led
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // Helpers
  // ----------
  logic           pa, pb, poa, pob;
  logic [LAT+5:0] hist;
  logic [3:0]     quiet;
  wire            d_a = i_quad_a ^ pa;
  wire            d_b = i_quad_b ^ pb;
  wire            out_step = (o_quad_a ^ poa) | (o_quad_b ^ pob);
  wire            cause = |{i_wire_break, i_low_amplitude,
                            i_core_overspeed, d_a & d_b};
  // Quiet saturates, so a stale cause cannot excuse a new error
  always_ff @(posedge i_clk) begin
    {pa, pb, poa, pob} <= {i_quad_a, i_quad_b, o_quad_a, o_quad_b};
    hist <= i_rst ? '0 : {hist[LAT+4:0], d_a | d_b};
    quiet <= i_rst ? 4'hF : cause ? 4'h0 : quiet + {3'h0, ~&quiet};
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // ----------
  // Properties
  // ----------
  property p_led; o_error_led == o_error; endproperty
  a_led: assert property (p_led)
    else $error("indicator differs from error output");
  property p_wire; (|i_wire_break) [*6] |-> o_error; endproperty
  a_wire: assert property (p_wire)
    else $error("wire break not flagged");
  property p_amp; (|i_low_amplitude) [*6] |-> o_error; endproperty
  a_amp: assert property (p_amp)
    else $error("low amplitude not flagged");
  property p_speed; i_core_overspeed [*4] |-> o_error; endproperty
  a_speed: assert property (p_speed)
    else $error("over-speed not flagged");
  // A live over-speed must outlast any acknowledge
  property p_hold; i_core_overspeed && o_error |=> o_error; endproperty
  a_hold: assert property (p_hold)
    else $error("error dropped during over-speed");
  // Reference pins are no cause, so a rise needs a recent one
  property p_cause; $rose(o_error) |-> quiet < 4'h8; endproperty
  a_cause: assert property (p_cause)
    else $error("error rose without a monitored cause");
  property p_gray; !($changed(o_quad_a) && $changed(o_quad_b)); endproperty
  a_gray: assert property (p_gray)
    else $error("both output phases changed at once");
  property p_lat; out_step |-> |hist[LAT+5:LAT+2]; endproperty
  a_lat: assert property (p_lat)
    else $error("output step not at pipeline depth");

  c_err: cover property ($rose(o_error));
  c_step: cover property (out_step);
  c_hold: cover property (i_core_overspeed && o_error);
endmodule

bind quadrature_divider_error_monitor quad_div_checker #(.LAT(LAT)) u_chk (
  .i_clk, .i_rst, .i_quad_a, .i_quad_b, .i_core_overspeed, .i_wire_break,
  .i_low_amplitude, .o_quad_a, .o_quad_b, .o_error, .o_error_led
);

// >>> dv/quad_rx_model.sv
// Downstream counter fed by the divided quadrature outputs
module quad_rx_model (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Divided signals
  input  wire logic i_a,
  input  wire logic i_b,
  input  wire logic i_z,
  // Counts seen
  output int        o_pos,
  output int        o_marks,
  output int        o_bad
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] prev;
  logic       prev_z;
  wire  [1:0] idx  = {i_a, i_a ^ i_b};
  wire  [1:0] diff = idx - prev;
  // A two-step jump loses direction, so it is counted as damage
  always @(posedge i_clk) begin
    prev   <= idx;
    prev_z <= i_z;
    if (i_rst) begin
      o_pos   <= 0;
      o_marks <= 0;
      o_bad   <= 0;
    end else begin
      if (diff == 2'h1) o_pos <= o_pos + 1;
      if (diff == 2'h3) o_pos <= o_pos - 1;
      if (diff == 2'h2) o_bad <= o_bad + 1;
      if (i_z && !prev_z) o_marks <= o_marks + 1;
    end
  end
endmodule

// >>> dv/testbench.sv
// Self-checking bench for the divider and error monitor
module testbench
  import quad_div_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic        i_quad_a = 1'b0, i_quad_b = 1'b0, i_ref_mark = 1'b0;
  logic        i_core_overspeed = 1'b0, i_error_release = 1'b0;
  logic        i_front_button = 1'b0, i_fault_mode_select = 1'b0;
  logic [3:0]  i_wire_break = 4'h0, i_low_amplitude = 4'h0;
  logic [3:0]  i_ref_div_code = 4'h0;
  logic [7:0]  i_phase_div_code = 8'h00, i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, seed = 32'h00FFA190;
  logic        o_quad_a, o_quad_b, o_ref_mark, o_error, o_error_led, o_irq;
  logic        rd_d = 1'b0;
  logic [1:0]  g = 2'h0;
  logic [31:0] eq[$], mq[$];
  int          n_errors = 0, num_checks = 0, pos, marks, bad, k;

  quadrature_divider_error_monitor #(.LAT(2)) dut (
    .i_clk, .i_rst, .i_quad_a, .i_quad_b, .i_ref_mark, .i_core_overspeed,
    .i_wire_break, .i_low_amplitude, .i_error_release, .i_front_button,
    .i_phase_div_code, .i_ref_div_code, .i_fault_mode_select, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .o_quad_a, .o_quad_b, .o_ref_mark,
    .o_error, .o_error_led, .o_irq
  );
  quad_rx_model u_rx (.i_clk, .i_rst, .i_a(o_quad_a), .i_b(o_quad_b),
    .i_z(o_ref_mark), .o_pos(pos), .o_marks(marks), .o_bad(bad));

  initial begin
    forever #25 i_clk = ~i_clk;
  end

  // ----------
  // Tasks
  // ----------
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, s);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    cyc(1);
    i_wr <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    eq.push_back(e);
    mq.push_back(m);
    i_rd <= 1'b1;
    i_addr <= a;
    cyc(1);
    i_rd <= 1'b0;
    cyc(2);
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge i_clk) begin
    rd_d <= i_rd;
    if (rd_d) chk("rdata", eq.pop_front(), o_rdata & mq.pop_front());
  end
  task automatic stp(input logic [1:0] d);
    g = g + d;
    {i_quad_a, i_quad_b} <= {g[1], g[1] ^ g[0]};
    cyc(2);
  endtask
  // Straps stay put through reset and capture
  task automatic boot(input logic [7:0] p, input logic [3:0] r, input m);
    i_rst <= 1'b1;
    i_phase_div_code <= p;
    i_ref_div_code <= r;
    i_fault_mode_select <= m;
    g = 2'h0;
    {i_quad_a, i_quad_b} <= 2'h0;
    cyc(6);
    i_rst <= 1'b0;
    cyc(8);
  endtask
  task automatic marks4();
    repeat (4) begin
      i_ref_mark <= 1'b1;
      cyc(3);
      i_ref_mark <= 1'b0;
      cyc(3);
    end
    cyc(20);
  endtask
  task automatic ack(input int how);
    if (how == 0) i_error_release <= 1'b1;
    else if (how == 1) i_front_button <= 1'b1;
    else wr(OFS_CTRL, 32'h1);
    cyc(4);
    i_error_release <= 1'b0;
    i_front_button <= 1'b0;
    cyc(8);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence: latched mode at 1:3, then self-clearing at 1:1
  initial begin
    boot(8'h02, 4'h1, 1'b0);
    rd(OFS_CONFIG, 32'h102, 32'h1FFF);
    wr(OFS_CONFIG, xs());
    i_phase_div_code <= seed[7:0];
    i_ref_div_code <= seed[11:8];
    i_fault_mode_select <= 1'b1;
    cyc(8);
    rd(OFS_CONFIG, 32'h102, 32'h1FFF);
    wr(OFS_MASK, 32'h1);
    repeat (9) stp(2'h1);
    cyc(20);
    chk("fwd", 3, pos);
    repeat (6) stp(2'h3);
    cyc(20);
    chk("back", 1, pos);
    chk("bad", 0, bad);
    marks4();
    chk("marks", 2, marks);
    chk("err", 0, o_error);
    for (k = 0; k < 8; k++) begin
      {i_low_amplitude, i_wire_break} <= 8'h01 << k;
      cyc(8);
      chk("err set", 32'h3, {o_error_led, o_error});
      {i_low_amplitude, i_wire_break} <= 8'h00;
      cyc(8);
      chk("err held", 1, o_error);
      ack(k % 3);
      chk("err clr", 0, o_error);
    end
    chk("irq", 1, o_irq);
    wr(OFS_STATUS, 32'h1);
    cyc(2);
    chk("irq", 0, o_irq);
    rd(OFS_STATUS, 32'hA, 32'hF);
    i_core_overspeed <= 1'b1;
    cyc(4);
    ack(0);
    chk("err speed", 1, o_error);
    rd(OFS_STATE, 32'hC, 32'h1F);
    i_core_overspeed <= 1'b0;
    ack(2);
    chk("err clr", 0, o_error);
    stp(2'h2);
    cyc(2);
    chk("err jump", 1, o_error);
    ack(1);
    chk("err clr", 0, o_error);
    wr(8'h14, xs());
    rd(8'h14, 32'h0, 32'hFFFFFFFF);
    boot(8'h00, 4'h3, 1'b1);
    rd(OFS_STATUS, 32'h0, 32'h10);
    repeat (80) stp(2'h1);
    cyc(20);
    chk("fwd", 80, pos);
    rd(OFS_STATUS, 32'h10, 32'h10);
    rd(OFS_STATE, 32'h10, 32'h1F);
    marks4();
    chk("marks", 1, marks);
    i_wire_break <= 4'h2;
    cyc(8);
    chk("err set", 1, o_error);
    i_wire_break <= 4'h0;
    cyc(8);
    chk("err auto", 0, o_error);
    end_sim();
  end

  // Watchdog: the sequence needs under 2000 cycles
  initial begin
    cyc(20000);
    n_errors++;
    end_sim();
  end
endmodule
